// ===== hdl/timer_channel.sv
// timer counter with one capture/compare/pwm channel and avalon-mm registers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - clock select: off, bus, fixed, external
// - pinless compare allowed with external clock
// - pin released when edge/level or clock off
// - center-aligned select puts channel in center_aligned_pwm
// - mode bits pick capture, compare, edge_aligned_pwm
// - capture on selected edge polarity
// - capture input synchronised to bus clock
// - compare match toggles, clears or sets pin
// - toggle keeps previous level until match
// - capture ignores value writes; control write unlatches
// - debug halt freezes latches, reads live
// - value bytes buffered, loaded coherently
// - clock off loads on second byte
// - compare loads at next counter change
// - pwm loads at modulo minus one step
// - control write resets write latch
// - debug halt writes go direct
// - one 16-bit counter with modulo
// - up/down in center_aligned_pwm, else up
module timer_channel
    import tmr_pkg::*;
#(
    parameter int PS_WIDTH = 3
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // timer sources and debug
    input  wire logic        fixed_clock_tick,
    input  wire logic        debug_halt_mode,
    // channel pin (also external counter clock source)
    input  wire logic        channel_pin_in,
    output logic             channel_pin_out,
    output logic             channel_pin_oe
);

    logic rst_meta_reg, rst_sync_reg;
    logic rst_n;
    // reset released through two stages
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // registers
    logic [1:0]          counter_clock_select;
    logic [PS_WIDTH-1:0] prescale_sel_reg;
    logic                center_aligned_select;
    logic [15:0]         modulo_reg;
    logic [15:0]         count_reg;
    logic                count_down_reg;
    logic [PS_WIDTH+6:0] prescale_cnt_reg;
    chan_cfg_t           chan_reg;
    logic [15:0]         chan_val_reg;
    logic [15:0]         wbuf_reg;
    logic                wlatch_hi_reg, wlatch_lo_reg, load_pend_reg;
    logic [7:0]          rbuf_reg;
    logic                rlatch_reg;
    logic                pin_reg, oe_reg;

    wire logic [1:0] ch_mode  = chan_reg.mode;
    wire logic [1:0] ch_els   = chan_reg.edge_level;

    // one-cycle bus answer: waitrequest drops in the cycle after the request
    logic ack_reg;
    wire logic req    = (read | write) & ~ack_reg;
    wire logic wr_acc = write & ack_reg;
    wire logic rd_acc = read & ack_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) ack_reg <= 1'b0;
        else        ack_reg <= req;
    end
    // waitrequest has a flop of its own so the bus sees no gate after it
    logic wait_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) wait_reg <= 1'b1;
        else        wait_reg <= ~req;
    end
    assign waitrequest = wait_reg;

    // mode decode
    wire logic clk_on   = (counter_clock_select != CLKS_OFF);
    wire logic is_center_aligned_pwm  = center_aligned_select;
    wire logic is_capt  = !is_center_aligned_pwm && ch_mode == MS_CAPT;
    wire logic is_ocmp  = !is_center_aligned_pwm && ch_mode == MS_OCMP;
    wire logic is_edge_aligned_pwm  = !is_center_aligned_pwm && ch_mode[1];
    wire logic ext_sel  = counter_clock_select == CLKS_EXT;
    // pin owned only with edge/level set and clock running
    wire logic pin_own  = clk_on && ch_els != ELS_NONE;

    // pin input synchroniser and edge detect
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= channel_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end
    wire logic rise = pin_s2_reg & ~pin_s3_reg;
    wire logic fall = ~pin_s2_reg & pin_s3_reg;

    // capture edge decode: rising, falling or both; code 0:0 never captures
    function automatic logic capture_edge(input logic [1:0] els, input logic r,
                                          input logic f);
        case (els)
            ELS_TOG: capture_edge = r;
            ELS_CLR: capture_edge = f;
            ELS_SET: capture_edge = r | f;
            default: capture_edge = 1'b0;
        endcase
    endfunction : capture_edge
    wire logic cap_ev = is_capt && pin_own && capture_edge(ch_els, rise, fall);

    // counter tick: external rising edge only usable up to a quarter bus rate
    logic src_tick;
    always_comb begin
        case (counter_clock_select)
            CLKS_BUS: src_tick = 1'b1;
            CLKS_FIX: src_tick = fixed_clock_tick;
            CLKS_EXT: src_tick = rise;
            default:  src_tick = 1'b0;
        endcase
    end

    // prescaler: divide by 2**prescale_sel
    wire logic [PS_WIDTH+6:0] ps_limit =
        (PS_WIDTH+7)'((1 << prescale_sel_reg) - 1);
    wire logic cnt_step = src_tick && prescale_cnt_reg >= ps_limit;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)              prescale_cnt_reg <= '0;
        else if (!clk_on)        prescale_cnt_reg <= '0;
        else if (cnt_step)       prescale_cnt_reg <= '0;
        else if (src_tick)       prescale_cnt_reg <= prescale_cnt_reg + 1'b1;
    end

    // main counter
    wire logic [15:0] top = (modulo_reg == CNT_ZERO) ? CNT_TOP : modulo_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg      <= CNT_ZERO;
            count_down_reg <= 1'b0;
        end else if (cnt_step) begin
            if (is_center_aligned_pwm) begin
                if (!count_down_reg && count_reg >= top) begin
                    count_down_reg <= 1'b1;
                    count_reg      <= count_reg - CNT_ONE;
                end else if (count_down_reg && count_reg <= CNT_ONE) begin
                    count_down_reg <= 1'b0;
                    count_reg      <= count_down_reg && count_reg == CNT_ZERO
                                      ? CNT_ONE : CNT_ZERO;
                end else if (count_down_reg) count_reg <= count_reg - CNT_ONE;
                else                         count_reg <= count_reg + CNT_ONE;
            end else begin
                count_down_reg <= 1'b0;
                // wrap after modulo, or after all ones when modulo is zero
                count_reg <= (count_reg >= top) ? CNT_ZERO
                                                : count_reg + CNT_ONE;
            end
        end
    end

    // pwm reload point: counter stepping from top minus one to top
    wire logic pwm_reload = cnt_step && !count_down_reg
                            && count_reg == top - CNT_ONE;
    wire logic match = cnt_step && count_reg == chan_val_reg;

    // value register writes
    wire logic wr_ctrl = wr_acc && address == ADDR_CH_CTRL;
    wire logic wr_vh   = wr_acc && address == ADDR_CH_VAL_HIGH && !is_capt;
    wire logic wr_vl   = wr_acc && address == ADDR_CH_VAL_LOW  && !is_capt;
    wire logic both    = (wr_vh | wlatch_hi_reg) & (wr_vl | wlatch_lo_reg);
    logic      apply;
    always_comb begin
        if (!clk_on)       apply = 1'b1;
        else if (is_ocmp)  apply = cnt_step;
        else               apply = pwm_reload;
    end

    // coherent write buffer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wbuf_reg      <= CNT_ZERO;
            wlatch_hi_reg <= 1'b0;
            wlatch_lo_reg <= 1'b0;
            load_pend_reg <= 1'b0;
        end else if (wr_ctrl) begin
            wlatch_hi_reg <= 1'b0;
            wlatch_lo_reg <= 1'b0;
            load_pend_reg <= 1'b0;
        end else if (!debug_halt_mode) begin
            if (wr_vh) wbuf_reg[15:8] <= writedata[7:0];
            if (wr_vl) wbuf_reg[7:0]  <= writedata[7:0];
            if (both && !load_pend_reg) begin
                wlatch_hi_reg <= 1'b0;
                wlatch_lo_reg <= 1'b0;
                load_pend_reg <= ~apply;
            end else begin
                wlatch_hi_reg <= wlatch_hi_reg | wr_vh;
                wlatch_lo_reg <= wlatch_lo_reg | wr_vl;
                if (load_pend_reg && apply) load_pend_reg <= 1'b0;
            end
        end
    end
    wire logic do_load = !debug_halt_mode && !wr_ctrl
                         && ((both && !load_pend_reg && apply)
                             || (load_pend_reg && apply));

    // channel value: loads from buffer, captures, or direct debug writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) chan_val_reg <= CNT_ZERO;
        else if (cap_ev)
            chan_val_reg <= count_reg;
        else if (debug_halt_mode) begin
            if (wr_vh) chan_val_reg[15:8] <= writedata[7:0];
            if (wr_vl) chan_val_reg[7:0]  <= writedata[7:0];
        end else if (do_load)
            chan_val_reg <= both && !load_pend_reg ?
                {wr_vh ? writedata[7:0] : wbuf_reg[15:8],
                 wr_vl ? writedata[7:0] : wbuf_reg[7:0]} : wbuf_reg;
    end

    // read coherency: outside debug halt a high byte read freezes the low byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rbuf_reg   <= 8'h00;
            rlatch_reg <= 1'b0;
        end else if (wr_ctrl) rlatch_reg <= 1'b0;
        else if (!debug_halt_mode) begin
            if (rd_acc && address == ADDR_CH_VAL_HIGH) begin
                rbuf_reg   <= chan_val_reg[7:0];
                rlatch_reg <= 1'b1;
            end else if (rd_acc && address == ADDR_CH_VAL_LOW)
                rlatch_reg <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            counter_clock_select  <= CLKS_OFF;
            prescale_sel_reg      <= '0;
            center_aligned_select <= 1'b0;
            modulo_reg            <= CNT_ZERO;
        end else if (wr_acc) begin
            if (address == ADDR_STATUS_CTRL) begin
                counter_clock_select  <= writedata[CLKS_LSB +: 2];
                prescale_sel_reg      <= writedata[PS_LSB +: PS_WIDTH];
                center_aligned_select <= writedata[CENTER_ALIGNED_SELECT_BIT];
            end else if (address == ADDR_MOD_HIGH)
                modulo_reg[15:8] <= writedata[7:0];
            else if (address == ADDR_MOD_LOW)
                modulo_reg[7:0]  <= writedata[7:0];
        end
    end

    // channel control; match/capture flag set wins over a software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) chan_reg <= '0;
        else begin
            if (wr_ctrl) begin
                chan_reg.mode       <= writedata[MS_LSB +: 2];
                chan_reg.edge_level <= writedata[ELS_LSB +: 2];
            end
            if (match || cap_ev)            chan_reg.flag <= 1'b1;
            else if (wr_ctrl && !writedata[CHF_BIT]) chan_reg.flag <= 1'b0;
        end
    end

    // pin drive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            // external clock pin keeps compare pinless by els 0:0
            oe_reg <= pin_own && !is_capt && !(ext_sel && ch_els == ELS_NONE);
            if (!pin_own) pin_reg <= pin_reg;
            else if (is_ocmp && match) begin
                case (ch_els)
                    ELS_TOG: pin_reg <= ~pin_reg;
                    ELS_CLR: pin_reg <= 1'b0;
                    default: pin_reg <= 1'b1;
                endcase
            end else if (is_edge_aligned_pwm && cnt_step) begin
                if (count_reg >= top)                pin_reg <= ~ch_els[0];
                else if (count_reg + CNT_ONE == chan_val_reg) pin_reg <= ch_els[0];
            end else if (is_center_aligned_pwm && cnt_step)
                pin_reg <= ((count_reg < chan_val_reg) ^ ch_els[0]);
        end
    end
    assign channel_pin_out = pin_reg;
    assign channel_pin_oe  = oe_reg;

    // read data, registered on the edge that drops waitrequest
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = RD_ZERO;
        if (address == ADDR_STATUS_CTRL)
            rd_mux = 32'({center_aligned_select, prescale_sel_reg, counter_clock_select});
        else if (address == ADDR_COUNT)      rd_mux = 32'(count_reg);
        else if (address == ADDR_MOD_HIGH)   rd_mux = 32'(modulo_reg[15:8]);
        else if (address == ADDR_MOD_LOW)    rd_mux = 32'(modulo_reg[7:0]);
        else if (address == ADDR_CH_CTRL)
            rd_mux = 32'({chan_reg.flag, 3'b000, chan_reg.mode, chan_reg.edge_level});
        else if (address == ADDR_CH_VAL_HIGH) rd_mux = 32'(chan_val_reg[15:8]);
        else if (address == ADDR_CH_VAL_LOW)
            rd_mux = 32'((rlatch_reg && !debug_halt_mode) ? rbuf_reg : chan_val_reg[7:0]);
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)        readdata <= RD_ZERO;
        else if (read & req) readdata <= rd_mux;
    end

endmodule : timer_channel

`default_nettype wire

// ===== hdl/tmr_pkg.sv
// package: register map, field codes and constants for the timer channel block
package tmr_pkg;

    // register word offsets (byte addresses on the avalon bus)
    localparam logic [4:0] ADDR_STATUS_CTRL  = 5'h00;  // counter control
    localparam logic [4:0] ADDR_COUNT        = 5'h04;  // counter value (read only)
    localparam logic [4:0] ADDR_MOD_HIGH     = 5'h08;
    localparam logic [4:0] ADDR_MOD_LOW      = 5'h0C;
    localparam logic [4:0] ADDR_CH_CTRL      = 5'h10;  // channel status/control
    localparam logic [4:0] ADDR_CH_VAL_HIGH  = 5'h14;
    localparam logic [4:0] ADDR_CH_VAL_LOW   = 5'h18;

    // counter control field positions
    localparam int CLKS_LSB  = 0;
    localparam int PS_LSB    = 2;
    localparam int CENTER_ALIGNED_SELECT_BIT = 5;
    // channel control field positions
    localparam int ELS_LSB   = 0;
    localparam int MS_LSB    = 2;
    localparam int CHF_BIT   = 7;

    // clock select codes
    localparam logic [1:0] CLKS_OFF  = 2'h0;
    localparam logic [1:0] CLKS_BUS  = 2'h1;
    localparam logic [1:0] CLKS_FIX  = 2'h2;
    localparam logic [1:0] CLKS_EXT  = 2'h3;
    // mode select codes
    localparam logic [1:0] MS_CAPT   = 2'h0;
    localparam logic [1:0] MS_OCMP   = 2'h1;
    // edge/level codes
    localparam logic [1:0] ELS_NONE  = 2'h0;
    localparam logic [1:0] ELS_TOG   = 2'h1;  // also rising edge in capture
    localparam logic [1:0] ELS_CLR   = 2'h2;  // also falling edge in capture
    localparam logic [1:0] ELS_SET   = 2'h3;  // also both edges in capture

    localparam logic [15:0] CNT_TOP   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // channel configuration, travels as one bundle
    typedef struct packed {
        logic       flag;
        logic [1:0] mode;
        logic [1:0] edge_level;
    } chan_cfg_t;

endpackage : tmr_pkg

// ===== sim/pin_source.sv
// external signal source on the channel pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    // pin wires
    input  wire logic mclk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in
);
    logic src_level;
    // resolved wire: the timer wins while it drives, else the outside source
    assign pin_in = pin_oe ? pin_out : src_level;
    initial src_level = 1'b0;
    // whole-cycle pulses only, never faster than a quarter of the bus rate
    // as counter clock it is pulsed only while the channel leaves the pin alone
    task automatic pulse(input logic [7:0] len);
        @(posedge mclk);
        src_level <= 1'b1;
        repeat (len) @(posedge mclk);
        src_level <= 1'b0;
    endtask : pulse
endmodule : pin_source
`default_nettype wire

// ===== sim/timer_channel_asserts.sv
// checker: bus handshake and pin ownership of the timer channel
`timescale 1ns/1ps
`default_nettype none
module timer_channel_asserts
    import tmr_pkg::*;
(
    // watched ports
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        fixed_clock_tick,
    input wire logic        debug_halt_mode,
    input wire logic        channel_pin_in,
    input wire logic        channel_pin_out,
    input wire logic        channel_pin_oe
);
    logic [7:0] ctrl_sh;
    logic [7:0] chan_sh;
    logic       clk_on;
    logic       els_on;
    logic       center_aligned_pwm;
    logic       ocmp;
    logic       capt;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // shadow copies of both control registers, taken at accepted writes only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_sh <= 8'h00;
            chan_sh <= 8'h00;
        end else if (write && !waitrequest) begin
            if (address == ADDR_STATUS_CTRL) ctrl_sh <= writedata[7:0];
            if (address == ADDR_CH_CTRL) chan_sh <= writedata[7:0];
        end
    end
    // decoded pin ownership; the external clock case is left out on purpose
    assign clk_on = ctrl_sh[CLKS_LSB +: 2] != CLKS_OFF;
    assign els_on = chan_sh[ELS_LSB +: 2] != ELS_NONE;
    assign center_aligned_pwm   = ctrl_sh[CENTER_ALIGNED_SELECT_BIT];
    assign ocmp   = !center_aligned_pwm && chan_sh[MS_LSB +: 2] == MS_OCMP && els_on && clk_on
                    && ctrl_sh[CLKS_LSB +: 2] != CLKS_EXT;
    assign capt   = !center_aligned_pwm && chan_sh[MS_LSB +: 2] == MS_CAPT && els_on && clk_on;

    chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    chk_ack_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_ack_cause: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("answer without a request");
    chk_off_release: assert property (!clk_on [*4] |-> !channel_pin_oe)
        else $error("pin driven with counter clock off");
    chk_els_release: assert property (!els_on [*4] |-> !channel_pin_oe)
        else $error("pin driven with edge/level select zero");
    chk_cmp_drive: assert property (ocmp [*4] |-> channel_pin_oe)
        else $error("compare mode does not drive the pin");
    chk_capt_input: assert property (capt [*4] |-> !channel_pin_oe)
        else $error("capture mode drives the pin");
    chk_center_aligned_pwm_drive: assert property ((center_aligned_pwm && els_on && clk_on) [*4] |-> channel_pin_oe)
        else $error("center aligned mode does not drive the pin");

    cover property (ocmp && channel_pin_out);
    cover property (capt && $rose(channel_pin_in));
    cover property (center_aligned_pwm && channel_pin_oe);
endmodule : timer_channel_asserts
bind timer_channel timer_channel_asserts i_timer_channel_asserts (.mclk, .resetn, .address,
    .read, .write, .writedata, .readdata, .waitrequest, .fixed_clock_tick, .debug_halt_mode,
    .channel_pin_in, .channel_pin_out, .channel_pin_oe);
`default_nettype wire

// ===== sim/timer_channel_tb.sv
// self-checking testbench of the timer channel
`timescale 1ns/1ps
`default_nettype none
module timer_channel_tb;
    import tmr_pkg::*;
    logic        mclk, resetn, read, write, waitrequest, fixed_clock_tick, debug_halt_mode;
    logic        channel_pin_in, channel_pin_out, channel_pin_oe;
    logic [4:0]  address;
    logic [31:0] writedata, readdata;
    logic [15:0] v, c1, c2, n;
    int          miscompares, cmp_count;

    timer_channel i_timer_channel (.mclk(mclk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .fixed_clock_tick(fixed_clock_tick),
        .debug_halt_mode(debug_halt_mode), .channel_pin_in(channel_pin_in),
        .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe));
    pin_source i_pin_source (.mclk(mclk), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
        .pin_in(channel_pin_in));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // slow tick for the fixed clock source
    always @(posedge mclk) fixed_clock_tick <= ~fixed_clock_tick;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [15:0] q);
        int k;
        k = 0;
        @(posedge mclk);
        address   <= a;
        writedata <= {24'h00_0000, d};
        read      <= !wr;
        write     <= wr;
        do begin
            @(posedge mclk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata[15:0];
        read  <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            miscompares++;
            complete_run();
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    // channel value read high byte first, so outside debug halt the low byte comes from the latch
    task automatic rd16(output logic [15:0] q);
        logic [15:0] h, l;
        bus(1'b0, ADDR_CH_VAL_HIGH, 8'h00, h);
        bus(1'b0, ADDR_CH_VAL_LOW, 8'h00, l);
        q = {h[7:0], l[7:0]};
    endtask : rd16

    // edges until the pin shows level b, bounded
    task automatic wait_pin(input logic b, output logic [15:0] cnt);
        cnt = 16'h0000;
        while (channel_pin_out !== b && cnt < 16'h0064) begin
            @(posedge mclk);
            cnt++;
        end
        if (cnt >= 16'h0064) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_pin

    task automatic t_off_load();
        bus(1'b0, ADDR_COUNT, 8'h00, v);
        check(v, 16'h0000);
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_SET});
        wr(ADDR_CH_VAL_LOW, 8'h34);
        rd16(v);
        check(v, 16'h0000);
        wr(ADDR_CH_VAL_HIGH, 8'h12);
        rd16(v);
        check(v, 16'h1234);
        wr(ADDR_CH_VAL_LOW, 8'h56);
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_SET});
        wr(ADDR_CH_VAL_HIGH, 8'h78);
        rd16(v);
        check(v, 16'h1234);
        check({15'h0000, channel_pin_oe}, 16'h0000);
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_SET});
        $display("clock off load done");
    endtask : t_off_load

    task automatic t_debug();
        wr(ADDR_CH_VAL_LOW, 8'h11);
        @(posedge mclk);
        debug_halt_mode <= 1'b1;
        wr(ADDR_CH_VAL_HIGH, 8'h22);
        rd16(v);
        check(v, 16'h2234);
        @(posedge mclk);
        debug_halt_mode <= 1'b0;
        wr(ADDR_CH_VAL_HIGH, 8'h33);
        rd16(v);
        check(v, 16'h3311);
        $display("debug halt done");
    endtask : t_debug

    task automatic t_compare();
        wr(ADDR_MOD_HIGH, 8'h00);
        wr(ADDR_MOD_LOW, 8'h0F);
        wr(ADDR_CH_VAL_HIGH, 8'h00);
        wr(ADDR_CH_VAL_LOW, 8'h05);
        wr(ADDR_STATUS_CTRL, {6'h00, CLKS_BUS});
        wait_pin(1'b1, n);
        check({15'h0000, channel_pin_oe}, 16'h0001);
        repeat (8) begin
            bus(1'b0, ADDR_COUNT, 8'h00, v);
            check(v & 16'hFFF0, 16'h0000);
        end
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_TOG});
        check({15'h0000, channel_pin_out}, 16'h0001);
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        check(n, 16'h0010);
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_CLR});
        wait_pin(1'b0, n);
        check(n & 16'hFFE0, 16'h0000);
        $display("compare done");
    endtask : t_compare

    task automatic t_capture();
        wr(ADDR_MOD_HIGH, 8'h00);
        wr(ADDR_MOD_LOW, 8'h00);
        wr(ADDR_CH_CTRL, {4'h0, MS_CAPT, ELS_TOG});
        wr(ADDR_CH_VAL_HIGH, 8'hAA);
        bus(1'b0, ADDR_COUNT, 8'h00, c1);
        i_pin_source.pulse(8'h04);
        repeat (4) @(posedge mclk);
        bus(1'b0, ADDR_COUNT, 8'h00, c2);
        rd16(v);
        check({15'h0000, channel_pin_oe}, 16'h0000);
        check({15'h0000, v >= c1 && v <= c2}, 16'h0001);
        $display("capture done");
    endtask : t_capture

    task automatic t_center_aligned_pwm();
        logic down;
        down = 1'b0;
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_SET});
        wr(ADDR_MOD_LOW, 8'h0F);
        wr(ADDR_STATUS_CTRL, 8'h21);
        bus(1'b0, ADDR_COUNT, 8'h00, c1);
        repeat (16) begin
            bus(1'b0, ADDR_COUNT, 8'h00, c2);
            if (c2 < c1 && c1 - c2 < 16'h0006) down = 1'b1;
            c1 = c2;
        end
        check({15'h0000, channel_pin_oe}, 16'h0001);
        check({15'h0000, down}, 16'h0001);
        $display("center aligned done");
    endtask : t_center_aligned_pwm

    // edge-aligned pwm on the fixed clock: one step every two edges, duty 8 of 16
    task automatic t_edge_aligned_pwm();
        wr(ADDR_STATUS_CTRL, {6'h00, CLKS_FIX});
        wr(ADDR_CH_CTRL, {4'h0, 2'h2, ELS_CLR}); // mode 1:0, high-true pulses
        wr(ADDR_CH_VAL_HIGH, 8'h00);
        wr(ADDR_CH_VAL_LOW, 8'h08);
        // skip early periods: the new duty is surely loaded before the last one
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        check(n, 16'h0010);
        rd16(v);
        check(v, 16'h0008);
        bus(1'b0, ADDR_CH_CTRL, 8'h00, v);
        check(v, 16'h008A);
        $display("edge aligned pwm done");
    endtask : t_edge_aligned_pwm

    // pinless compare channel while the pin clocks the counter
    task automatic t_ext_clock();
        wr(ADDR_CH_CTRL, {4'h0, MS_OCMP, ELS_NONE});
        wr(ADDR_MOD_LOW, 8'h00);
        wr(ADDR_STATUS_CTRL, {6'h00, CLKS_EXT});
        bus(1'b0, ADDR_COUNT, 8'h00, c1);
        repeat (2) begin
            i_pin_source.pulse(8'h04);
            repeat (4) @(posedge mclk);
        end
        bus(1'b0, ADDR_COUNT, 8'h00, c2);
        check(c2 - c1, 16'h0002);
        check({15'h0000, channel_pin_oe}, 16'h0000);
        $display("external clock done");
    endtask : t_ext_clock

    // reset, then the scenarios in order
    initial begin
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        fixed_clock_tick = 1'b0;
        debug_halt_mode = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        check({14'h0000, waitrequest, channel_pin_oe}, 16'h0002);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_off_load();
        t_debug();
        t_compare();
        t_capture();
        t_center_aligned_pwm();
        t_edge_aligned_pwm();
        t_ext_clock();
        complete_run();
    end
endmodule : timer_channel_tb
`default_nettype wire
